/* File: inc/ftogc_pkg.sv */
// Package for the frame timing, offset and gain control block
package ftogc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_GAIN_GR = 8'h00;
  localparam logic [7:0] A_GAIN_R  = 8'h01;
  localparam logic [7:0] A_GAIN_B  = 8'h02;
  localparam logic [7:0] A_GAIN_GB = 8'h03;
  localparam logic [7:0] A_EXPGAIN = 8'h10;
  localparam logic [7:0] A_GMODE   = 8'h11;
  localparam logic [7:0] A_CTRL    = 8'h20;
  localparam logic [7:0] A_CROWS   = 8'h21;
  localparam logic [7:0] A_VRD_H   = 8'h22;
  localparam logic [7:0] A_VRD_L   = 8'h23;
  localparam logic [7:0] A_VCW_H   = 8'h24;
  localparam logic [7:0] A_VCW_L   = 8'h25;
  localparam logic [7:0] A_SHS     = 8'h26;
  localparam logic [7:0] A_SHR     = 8'h27;
  localparam logic [7:0] A_CINT_H  = 8'h28;
  localparam logic [7:0] A_CINT_L  = 8'h29;
  localparam logic [7:0] A_STATUS  = 8'h2A;
  localparam logic [7:0] A_COL_DC  = 8'h2F;
  localparam logic [7:0] A_COL_BASE = 8'h40;
  // ****************************************
  // Field positions, counts and reset values
  // ****************************************
  localparam int CTRL_SINGLE = 0;
  localparam int CTRL_CLAMP_ON = 1;
  localparam int CTRL_CLAMP_AUTO = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam logic [11:0] ROW_EXTRA = 12'h013;
  localparam logic [10:0] DARK_SKIP = 11'h003;
  localparam logic [7:0] DARK_SAMPLE = 8'h02;
  localparam logic [5:0] COL_DC_RST = 6'h00;
  localparam logic [5:0] GAIN_RST = 6'h00;
  localparam logic [10:0] VRD_RST = 11'h40A;
  localparam logic [10:0] VCW_RST = 11'h50A;
  localparam logic [7:0] SH_RST = 8'h0A;
  localparam logic [15:0] CINT_RST = 16'h015E;
  localparam int NCOL = 64;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {GM_RAW, GM_LINEAR, GM_LINEAR_TWO} ftogc_gmode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_READ} ftogc_st_t;
  typedef struct packed {
    logic [10:0] vrd;
    logic [10:0] vcw;
    logic [7:0]  shs;
    logic [7:0]  shr;
    logic [15:0] cint;
  } ftogc_tim_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ftogc_req_t;
  typedef struct packed {
    logic [5:0] wb_gain;
    logic [5:0] exp_gain;
    logic [1:0] gain_mode;
    logic [6:0] col_offset;
  } ftogc_pix_t;
endpackage : ftogc_pkg

/* File: rtl/ftogc_core.sv */
// Row/frame timing, dark clamp sequencing, column offsets and gain selection
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Single frame: frame is integration plus readout
// - Row lasts vcw + shs + shr + 19 clocks
// - Single frame integration not limited by frame
// - Integration is (cint + 1) row times; continuous mode caps it at vrd rows, or one row when vrd is zero
// - Sync starts integration; idle after readout
// - Auto clamp re-runs every frame
// - Skip 3 dark rows, sample next 2
// - Clamping holds dark level, forces common mode
// - Clamp can be disabled; row count programmable
// - 64 signed-magnitude 6-bit column offsets
// - DC term added, repeats every 64 columns
// - Column DC register resets to zero
// - Four 6-bit white balance gains
// - Gain addresses: GR, R, B, GB
// - Gain writes take effect immediately
// - 6-bit exposure gain with three modes
module ftogc_core
  import ftogc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire ftogc_req_t reg_req,
  output logic [7:0]      reg_rdata,
  input  wire logic       sync_in,
  output logic            frame_start,
  output logic            row_start,
  output logic            integ_active,
  output logic            read_active,
  output logic            clamp_active,
  output logic [16:0]     int_rows,
  output ftogc_pix_t      pix
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ftogc_st_t        st;
    logic [11:0]      cyc;
    logic [10:0]      row;
    logic [15:0]      icnt;
    logic [2:0]       sy;
    logic             sy_lvl;
    logic [3:0][5:0]  gain;
    logic [5:0]       egain;
    logic [1:0]       gmode;
    logic [2:0]       ctrl;
    logic [7:0]       crows;
    ftogc_tim_t       live;
    ftogc_tim_t       tim;
    logic [63:0][5:0] coff;
    logic [5:0]       dc;
    logic [7:0]       rdata;
    logic             fgo;
    logic             rgo;
    logic             clamp;
    logic [16:0]      irows;
    ftogc_pix_t       pix;
  } ftogc_state_t;

  ftogc_state_t q;
  ftogc_state_t d;
  logic [11:0]  row_len;
  logic         tick;
  logic         sync_ev;
  logic         single;
  logic [15:0]  cint_lim;

  function automatic logic [6:0] sm2tc(input logic [5:0] v);
    logic [6:0] m;
    m = {2'h0, v[4:0]};
    sm2tc = v[5] ? 7'(-m) : m;
  endfunction : sm2tc

  assign single = q.ctrl[CTRL_SINGLE];
  assign row_len = 12'(q.tim.vcw) + 12'(q.tim.shs) + 12'(q.tim.shr) + ROW_EXTRA;
  assign tick = (q.cyc == row_len - 12'h001);
  // Second and third stage must agree before a level counts
  assign sync_ev = (q.sy[1] == q.sy[2]) && q.sy[2] && !q.sy_lvl;
  // Continuous mode keeps integration strictly shorter than the frame, except when vrd is zero
  assign cint_lim = (q.tim.vrd == 11'h000) ? 16'h0000 : 16'(q.tim.vrd - 11'h001);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.fgo = 1'b0;
    d.rgo = 1'b0;
    d.sy = {q.sy[1:0], sync_in};
    if (q.sy[1] == q.sy[2])
    begin
      d.sy_lvl = q.sy[2];
    end
    // Register port
    if (reg_req.wr)
    begin
      if (reg_req.addr <= A_GAIN_GB)
      begin
        d.gain[reg_req.addr[1:0]] = reg_req.wdata[5:0];
      end
      else if (reg_req.addr == A_EXPGAIN)
      begin
        d.egain = reg_req.wdata[5:0];
      end
      else if (reg_req.addr == A_GMODE)
      begin
        d.gmode = (reg_req.wdata[1:0] == 2'h3) ? GM_RAW : reg_req.wdata[1:0];
      end
      else if (reg_req.addr == A_CTRL)
      begin
        d.ctrl = reg_req.wdata[2:0];
      end
      else if (reg_req.addr == A_CROWS)
      begin
        d.crows = reg_req.wdata;
      end
      else if (reg_req.addr == A_VRD_H)
      begin
        d.live.vrd[10:8] = reg_req.wdata[2:0];
      end
      else if (reg_req.addr == A_VRD_L)
      begin
        d.live.vrd[7:0] = reg_req.wdata;
      end
      else if (reg_req.addr == A_VCW_H)
      begin
        d.live.vcw[10:8] = reg_req.wdata[2:0];
      end
      else if (reg_req.addr == A_VCW_L)
      begin
        d.live.vcw[7:0] = reg_req.wdata;
      end
      else if (reg_req.addr == A_SHS)
      begin
        d.live.shs = reg_req.wdata;
      end
      else if (reg_req.addr == A_SHR)
      begin
        d.live.shr = reg_req.wdata;
      end
      else if (reg_req.addr == A_CINT_H)
      begin
        d.live.cint[15:8] = reg_req.wdata;
      end
      else if (reg_req.addr == A_CINT_L)
      begin
        d.live.cint[7:0] = reg_req.wdata;
      end
      else if (reg_req.addr == A_COL_DC)
      begin
        d.dc = reg_req.wdata[5:0];
      end
      else if (reg_req.addr >= A_COL_BASE && reg_req.addr < A_COL_BASE + 8'(NCOL))
      begin
        d.coff[reg_req.addr[5:0]] = reg_req.wdata[5:0];
      end
    end
    if (reg_req.rd)
    begin
      if (reg_req.addr <= A_GAIN_GB)
      begin
        d.rdata = {2'h0, q.gain[reg_req.addr[1:0]]};
      end
      else if (reg_req.addr == A_EXPGAIN)
      begin
        d.rdata = {2'h0, q.egain};
      end
      else if (reg_req.addr == A_GMODE)
      begin
        d.rdata = {6'h00, q.gmode};
      end
      else if (reg_req.addr == A_CTRL)
      begin
        d.rdata = {5'h00, q.ctrl};
      end
      else if (reg_req.addr == A_CROWS)
      begin
        d.rdata = q.crows;
      end
      else if (reg_req.addr == A_VRD_H)
      begin
        d.rdata = {5'h00, q.live.vrd[10:8]};
      end
      else if (reg_req.addr == A_VRD_L)
      begin
        d.rdata = q.live.vrd[7:0];
      end
      else if (reg_req.addr == A_VCW_H)
      begin
        d.rdata = {5'h00, q.live.vcw[10:8]};
      end
      else if (reg_req.addr == A_VCW_L)
      begin
        d.rdata = q.live.vcw[7:0];
      end
      else if (reg_req.addr == A_SHS)
      begin
        d.rdata = q.live.shs;
      end
      else if (reg_req.addr == A_SHR)
      begin
        d.rdata = q.live.shr;
      end
      else if (reg_req.addr == A_CINT_H)
      begin
        d.rdata = q.live.cint[15:8];
      end
      else if (reg_req.addr == A_CINT_L)
      begin
        d.rdata = q.live.cint[7:0];
      end
      else if (reg_req.addr == A_STATUS)
      begin
        d.rdata = {4'h0, q.clamp, q.sy_lvl, q.st};
      end
      else if (reg_req.addr == A_COL_DC)
      begin
        d.rdata = {2'h0, q.dc};
      end
      else if (reg_req.addr >= A_COL_BASE && reg_req.addr < A_COL_BASE + 8'(NCOL))
      begin
        d.rdata = {2'h0, q.coff[reg_req.addr[5:0]]};
      end
      else
      begin
        d.rdata = 8'h00;
      end
    end
    // Row and frame sequencing
    d.cyc = (q.st == ST_IDLE || tick) ? 12'h000 : q.cyc + 12'h001;
    d.rgo = (q.st != ST_IDLE) && tick;
    case (q.st)
      ST_IDLE:
      begin
        d.row = 11'h000;
        d.icnt = 16'h0000;
        if (!single)
        begin
          d.st = ST_READ;
          d.tim = q.live;
          d.fgo = 1'b1;
        end
        else if (sync_ev)
        begin
          d.st = ST_INTEG;
          d.tim = q.live;
        end
      end
      ST_INTEG:
      begin
        if (tick)
        begin
          if (q.icnt == q.tim.cint)
          begin
            d.st = ST_READ;
            d.fgo = 1'b1;
          end
          else
          begin
            d.icnt = q.icnt + 16'h0001;
          end
        end
      end
      ST_READ:
      begin
        if (tick)
        begin
          if (q.row == q.tim.vrd)
          begin
            d.row = 11'h000;
            if (single)
            begin
              d.st = ST_IDLE;
            end
            else
            begin
              d.tim = q.live;
              d.fgo = 1'b1;
            end
          end
          else
          begin
            d.row = q.row + 11'h001;
          end
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase
    // A change of capture mode drops the frame in flight, so a host that leaves
    // the default continuous mode never waits out a long reset-size frame
    if (reg_req.wr && reg_req.addr == A_CTRL && reg_req.wdata[CTRL_SINGLE] != single)
    begin
      d.st = ST_IDLE;
      d.fgo = 1'b0;
    end
    // Integration in effect, counted in rows
    if (single)
    begin
      d.irows = 17'(q.tim.cint) + 17'h00001;
    end
    else
    begin
      d.irows = ((q.tim.cint > cint_lim) ? 17'(cint_lim) : 17'(q.tim.cint)) + 17'h00001;
    end
    // Dark rows sit at the top of every frame, so the clamp re-runs each frame
    d.clamp = 1'b0;
    if (q.st == ST_READ && q.ctrl[CTRL_CLAMP_ON] && q.row >= DARK_SKIP)
    begin
      if (q.ctrl[CTRL_CLAMP_AUTO])
      begin
        d.clamp = (q.row < DARK_SKIP + 11'(DARK_SAMPLE));
      end
      else
      begin
        d.clamp = (q.row < DARK_SKIP + 11'(q.crows));
      end
    end
    // Pixel path: offset index wraps every 64 columns
    d.pix.col_offset = sm2tc(q.coff[q.cyc[5:0]]) + sm2tc(q.dc);
    d.pix.wb_gain = q.gain[{q.row[0], q.cyc[0]}];
    d.pix.exp_gain = q.egain;
    d.pix.gain_mode = q.gmode;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.gain <= {4{GAIN_RST}};
      q.ctrl <= CTRL_RST;
      q.crows <= DARK_SAMPLE;
      q.live <= {VRD_RST, VCW_RST, SH_RST, SH_RST, CINT_RST};
      q.tim <= {VRD_RST, VCW_RST, SH_RST, SH_RST, CINT_RST};
      q.dc <= COL_DC_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign frame_start = q.fgo;
  assign row_start = q.rgo;
  assign integ_active = (q.st == ST_INTEG);
  assign read_active = (q.st == ST_READ);
  assign clamp_active = q.clamp;
  assign int_rows = q.irows;
  assign pix = q.pix;

  // ****************************************
  // Assertions
  // ****************************************
  logic [11:0] gap_q;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gap_q <= 12'h000;
    end
    else
    begin
      // Held at zero while idle so the first row of a frame is timed from its start
      gap_q <= q.rgo ? 12'h001 : ((q.st == ST_IDLE) ? 12'h000 : gap_q + 12'h001);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_row_period: assert property (q.rgo && $past(q.rgo, 2) == 1'b0 && gap_q > 12'h001 && $stable(q.tim)
    |-> gap_q == row_len) else $error("row period wrong");
  a_single_wait: assert property (q.st == ST_IDLE && single && !sync_ev |=> q.st == ST_IDLE)
    else $error("capture started without sync");
  a_integ_len: assert property (q.st == ST_INTEG ##1 q.st == ST_READ
    |-> $past(q.icnt) == q.tim.cint && q.fgo) else $error("integration length wrong");
  a_single_end: assert property (q.st == ST_READ && single && tick && q.row == q.tim.vrd
    |=> q.st == ST_IDLE) else $error("no stop after readout");
  // Integration stays below the frame; a zero row depth still integrates one row
  a_cont_limit: assert property (!single && q.st == ST_READ ##1 !single
    |=> q.irows <= 17'($past(q.tim.vrd)) || q.irows == 17'h00001)
    else $error("integration over frame");
  a_clamp_auto: assert property (q.clamp && q.ctrl[CTRL_CLAMP_AUTO] && $past(q.ctrl) == q.ctrl
    |-> $past(q.row) == 11'h003 || $past(q.row) == 11'h004) else $error("clamp row wrong");
  a_clamp_off: assert property (!q.ctrl[CTRL_CLAMP_ON] |=> !q.clamp)
    else $error("clamp while disabled");
  a_shadow_hold: assert property (q.st == ST_READ && !(tick && q.row == q.tim.vrd)
    |=> $stable(q.tim)) else $error("timing changed mid frame");
  a_gain_write: assert property (reg_req.wr && reg_req.addr == A_GAIN_R
    |=> q.gain[1] == $past(reg_req.wdata[5:0])) else $error("red gain not stored");
  a_col_sum: assert property (q.st == ST_READ ##1 1'b1
    |-> pix.col_offset == 7'($past(sm2tc(q.coff[q.cyc[5:0]]) + sm2tc(q.dc))))
    else $error("column offset sum wrong");

  c_single: cover property (q.st == ST_INTEG ##1 q.st == ST_READ);
  c_clamp: cover property ($rose(q.clamp));
  c_cont_frame: cover property (!single && q.fgo);
endmodule : ftogc_core
`default_nettype wire

/* File: verif/ftogc_host.sv */
// Host-side model that pulses the frame sync pin
`timescale 1ns/10ps
`default_nettype none
module ftogc_host
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic fire,
  output logic      sync_in
);
  logic [2:0] cnt_q;

  // **********************************
  // Sync pulse
  // **********************************
  // Held for four clocks so the pin synchroniser sees a clean level
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 3'h0;
    else if (fire)
      cnt_q <= 3'h4;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end

  assign sync_in = (cnt_q != 3'h0);
endmodule : ftogc_host
`default_nettype wire

/* File: verif/frame_timing_offset_gain_ctrl_tb.sv */
// Testbench for the frame timing, offset and gain control block
`timescale 1ns/10ps
`default_nettype none
module frame_timing_offset_gain_ctrl_tb
  import ftogc_pkg::*;
;
  localparam int ROW_LEN = 20 + 2 + 3 + int'(ROW_EXTRA);
  localparam int READ_LEN = 10 * ROW_LEN;

  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        sync_fire = 1'b0;
  ftogc_req_t  reg_req = '0;
  logic        sync_in;
  logic [7:0]  reg_rdata;
  logic        frame_start;
  logic        row_start;
  logic        integ_active;
  logic        read_active;
  logic        clamp_active;
  logic [16:0] int_rows;
  ftogc_pix_t  pix;
  int          n_int, n_rd, n_clamp, n_fs, gap, last_gap;
  int          fails = 0;
  int          n_tests = 0;
  int          i;

  always #12.5 ref_clk = ~ref_clk;

  ftogc_core ftogc_core_inst (
    .ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sync_in(sync_in), .frame_start(frame_start), .row_start(row_start),
    .integ_active(integ_active), .read_active(read_active),
    .clamp_active(clamp_active), .int_rows(int_rows), .pix(pix)
  );

  ftogc_host ftogc_host_inst (
    .ref_clk(ref_clk), .nrst(nrst), .fire(sync_fire), .sync_in(sync_in)
  );

  // **********************************
  // Monitors
  // **********************************
  always @(posedge ref_clk)
  begin
    if (integ_active === 1'b1) n_int++;
    if (read_active === 1'b1) n_rd++;
    if (clamp_active === 1'b1) n_clamp++;
    if (frame_start === 1'b1) n_fs++;
    if (row_start === 1'b1)
    begin
      last_gap = gap;
      gap = 1;
    end
    else
      gap++;
  end

  // **********************************
  // Tasks
  // **********************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD %s expected %0h seen %0h", nm, e, g);
      fails++;
    end
  endtask : chk

  // A gap cycle after each access keeps the strobe from being driven twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    @(negedge ref_clk);
    chk("reg_rdata", e, reg_rdata);
  endtask : rd_chk

  // Runs one single-frame capture; optionally rewrites cint during integration
  task automatic run_frame(input int e_int, input int e_clamp, input bit mid);
    int k;
    @(negedge ref_clk);
    n_int = 0;
    n_rd = 0;
    n_clamp = 0;
    n_fs = 0;
    @(posedge ref_clk);
    sync_fire <= 1'b1;
    @(posedge ref_clk);
    sync_fire <= 1'b0;
    k = 0;
    while (mid && integ_active !== 1'b1 && k < 100)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (mid)
      wr(A_CINT_L, 8'h02);
    k = 0;
    while ((n_rd == 0 || read_active !== 1'b0) && k < 5000)
    begin
      @(negedge ref_clk);
      k++;
    end
    // Idle stretch: no new frame may start without a fresh sync
    repeat (50) @(negedge ref_clk);
    chk("integ_cycles", e_int, n_int);
    chk("read_cycles", READ_LEN, n_rd);
    chk("clamp_cycles", e_clamp, n_clamp);
    chk("frame_starts", 1, n_fs);
    chk("row_len", ROW_LEN, last_gap);
    chk("int_rows", e_int / ROW_LEN, int_rows);
  endtask : run_frame

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // **********************************
  // Sequence
  // **********************************
  initial
  begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    // Leave continuous mode before its first long frame begins
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: A_CTRL, wdata: 8'h07};
    @(posedge ref_clk);
    reg_req <= '0;
    rd_chk(A_CTRL, 8'h07);
    rd_chk(A_COL_DC, {2'h0, COL_DC_RST});
    rd_chk(A_CROWS, 8'h02);
    rd_chk(8'h30, 8'h00);
    for (i = 0; i < 4; i++) rd_chk(A_GAIN_GR + i[7:0], {2'h0, GAIN_RST});
    for (i = 0; i < 4; i++) wr(A_GAIN_GR + i[7:0], 8'h11 + i[7:0]);
    for (i = 0; i < 4; i++) rd_chk(A_GAIN_GR + i[7:0], 8'h11 + i[7:0]);
    wr(A_EXPGAIN, 8'h3F);
    for (i = 0; i < 4; i++)
    begin
      wr(A_GMODE, i[7:0]);
      rd_chk(A_GMODE, (i == 3) ? 8'h00 : i[7:0]);
    end
    wr(A_GMODE, 8'h02);
    wr(A_VCW_H, 8'h00);
    wr(A_VCW_L, 8'h14);
    wr(A_SHS, 8'h02);
    wr(A_SHR, 8'h03);
    wr(A_VRD_H, 8'h00);
    wr(A_VRD_L, 8'h09);
    wr(A_CINT_H, 8'h00);
    wr(A_CINT_L, 8'h0C);
    run_frame(13 * ROW_LEN, 2 * ROW_LEN, 1'b1);
    run_frame(3 * ROW_LEN, 2 * ROW_LEN, 1'b0);
    wr(A_CTRL, 8'h03);
    wr(A_CROWS, 8'h04);
    run_frame(3 * ROW_LEN, 4 * ROW_LEN, 1'b0);
    wr(A_CTRL, 8'h01);
    run_frame(3 * ROW_LEN, 0, 1'b0);
    // Continuous capture: frames follow back to back, integration kept below the frame
    wr(A_CINT_L, 8'h20);
    wr(A_CTRL, 8'h06);
    @(negedge ref_clk);
    n_fs = 0;
    repeat (2 * READ_LEN + 10) @(negedge ref_clk);
    chk("cont_frames", 3, n_fs);
    chk("cont_int_rows", 9, int_rows);
    for (i = 0; i < NCOL; i++) wr(A_COL_BASE + i[7:0], 8'h23);
    wr(A_COL_DC, 8'h05);
    for (i = 0; i < 4; i++) wr(A_GAIN_GR + i[7:0], 8'h2A);
    repeat (4) @(negedge ref_clk);
    chk("col_offset", 7'h02, pix.col_offset);
    chk("wb_gain", 6'h2A, pix.wb_gain);
    chk("exp_gain", 6'h3F, pix.exp_gain);
    chk("gain_mode", 2'h2, pix.gain_mode);
    rd_chk(A_COL_BASE + 8'h3F, 8'h23);
    report_and_stop;
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    report_and_stop;
  end
endmodule : frame_timing_offset_gain_ctrl_tb
`default_nettype wire
